// ==== pac_autochange.v ====
// pac_autochange: pump/fan autochange sequencer with interlock handling
// assumes synchronous inputs, one 250 MHz clock, register port master as documented
// Summary of operation
// [R1] rotation never happens while enable is zero
// [R2] scope 0 rotates auxiliaries, own motor fixed
// [R3] scope 1 rotates all, two contactors each
// [R4] on interval expiry rotate if capacity permits
// [R5] blocked rotation held pending until capacity drops
// [R6] interval counts only while start request active
// [R7] interval counter cleared after each rotation
// [R8] fewer running aux than max permits rotation
// [R9] at max, rotate only below frequency limit
// [R10] zero limit rotates only in stop/sleep
// [R11] command only motors with interlock active
// [R12] each interlock taken from mapped digital input
// [R13] interlock mode 0 ignores all feedback
// [R14] mode 1 appends returned motor at end
// [R15] mode 1 restores ascending order at stop
// [R16] mode 2 stops all, restarts rebuilt order
// [R17] display value scaled with min, max, decimals
// [R18] rotation moves first motor to last place
// [R19] single clock, seconds tick, reset clears state
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "pac_map.vh"
module pac_autochange (
  input  wire             CLK,
  input  wire             RSTN,
  input  wire [`PAC_AW-1:0] ADDR,
  input  wire [31:0]      WDATA,
  input  wire             WR,
  input  wire             RD,
  output reg  [31:0]      RDATA,
  input  wire             START_REQ,
  input  wire             SLEEP,
  input  wire [15:0]      OUT_FREQ,
  input  wire [2:0]       AUX_DEMAND,
  input  wire [7:0]       DIG_IN,
  input  wire [15:0]      ACTUAL,
  output reg  [4:0]       LINE_CON,
  output reg  [4:0]       CONV_CON,
  output reg              DRIVE_RUN,
  output reg  [15:0]      DISP_VALUE,
  output reg  [3:0]       DISP_DECIMALS
);
  localparam ST_RUN  = 3'b001;
  localparam ST_STOP = 3'b010;
  localparam ST_HALT = 3'b100;

  reg [31:0] ctrl_q;
  reg [31:0] interval_q;
  reg [2:0]  maxaux_q;
  reg [15:0] flimit_q;
  reg [31:0] imap_q;
  reg [15:0] dmin_q;
  reg [15:0] dmax_q;
  reg [3:0]  ddec_q;
  reg [31:0] elapsed_q;
  reg        pending_q;
  reg [2:0]  state_q;
  reg [14:0] order_q;
  reg [2:0]  len_q;
  reg [4:0]  ilk_prev_q;
  reg [7:0]  rot_count_q;
  wire       tick;
  wire [15:0] disp_w;

  wire       en    = ctrl_q[`PAC_CTRL_EN_BIT];
  wire       scope = ctrl_q[`PAC_CTRL_SCOPE_BIT];
  wire [1:0] mode  = ctrl_q[`PAC_CTRL_MODE_HI:`PAC_CTRL_MODE_LO];
  wire [2:0] nmot  = scope ? 3'd5 : 3'd4;

  pac_tick #(.PERIOD(`PAC_TICK_CYCLES)) u_tick ( // R19
    .CLK  (CLK),
    .RSTN (RSTN),
    .tick (tick)
  );

  pac_scale u_scale ( // R17
    .CLK    (CLK),
    .RSTN   (RSTN),
    .actual (ACTUAL),
    .lo     (dmin_q),
    .hi     (dmax_q),
    .disp   (disp_w)
  );

  // interlock per motor from mapped digital input; motor 4 from bits 18:16 in either scope
  reg [4:0] ilk;
  integer   k;
  always @* begin
    ilk = 5'h1F;
    for (k = 0; k < 4; k = k + 1)
      ilk[k] = DIG_IN[imap_q[4*k +: 3]]; // [R12]
    ilk[4] = DIG_IN[imap_q[18:16]]; // [R12]
    if (mode == `PAC_MODE_NONE)
      ilk = 5'h1F; // [R13]
  end
  wire [4:0] ilk_rise = ilk & ~ilk_prev_q;
  wire [4:0] ilk_fall = ~ilk & ilk_prev_q;

  // running auxiliaries: positions 1..demand of the order (position 0 is the regulated one)
  wire [2:0] aux_run = (AUX_DEMAND < len_q) ? AUX_DEMAND : ((len_q == 3'd0) ? 3'd0 : len_q - 3'd1);
  wire at_rest = !START_REQ || SLEEP;
  wire cap_ok  = (flimit_q == 16'h0000) ? at_rest // [R10]
               : (aux_run < maxaux_q) ? 1'b1 // [R8]
               : (aux_run == maxaux_q) && (OUT_FREQ < flimit_q); // [R9]
  wire expired = (interval_q != 32'h00000000) && (elapsed_q >= interval_q);
  wire do_rot  = en && (expired || pending_q) && cap_ok && (state_q != ST_HALT); // [R1] [R4] [R5]

  // ascending order of permitted motors
  reg [14:0] asc;
  reg [2:0]  asc_len;
  integer    m;
  always @* begin
    asc     = 15'h0000;
    asc_len = 3'd0;
    for (m = 0; m < 5; m = m + 1) begin
      if ((m[2:0] < nmot) && ilk[m]) begin // [R11]
        asc[3*asc_len +: 3] = m[2:0];
        asc_len = asc_len + 3'd1;
      end
    end
  end

  // order with a dropped motor removed
  reg [14:0] pruned;
  reg [2:0]  pr_len;
  reg [2:0]  ent;
  integer    j;
  always @* begin
    pruned = 15'h0000;
    pr_len = 3'd0;
    ent    = 3'd0;
    for (j = 0; j < 5; j = j + 1) begin
      ent = order_q[3*j +: 3];
      if ((j[2:0] < len_q) && ilk[ent]) begin // [R11]
        pruned[3*pr_len +: 3] = ent;
        pr_len = pr_len + 3'd1;
      end
    end
  end

  // appended returning motor: lowest index only; others returning in the same cycle are not appended
  reg [2:0] ret_idx;
  reg       ret_any;
  integer   r;
  always @* begin
    ret_idx = 3'd0;
    ret_any = 1'b0;
    for (r = 4; r >= 0; r = r - 1) begin
      if (ilk_rise[r] && (r[2:0] < nmot)) begin
        ret_idx = r[2:0];
        ret_any = 1'b1;
      end
    end
  end

  wire stop_evt = do_rot || (state_q == ST_RUN && at_rest);

  // sequencer
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q     <= ST_STOP;
      order_q     <= 15'h0000;
      len_q       <= 3'd0;
      elapsed_q   <= 32'h00000000;
      pending_q   <= 1'b0;
      ilk_prev_q  <= 5'h1F;
      rot_count_q <= 8'h00;
    end else begin
      ilk_prev_q <= ilk;
      if (!en) begin
        pending_q <= 1'b0; // [R1]
        elapsed_q <= 32'h00000000;
      end else if (do_rot) begin
        pending_q <= 1'b0;
        elapsed_q <= 32'h00000000; // [R7]
      end else begin
        if (expired)
          pending_q <= 1'b1; // [R5]
        if (START_REQ && tick && !expired)
          elapsed_q <= elapsed_q + 32'd1; // [R6]
      end
      case (state_q)
        ST_RUN: begin
          if (ret_any && mode == `PAC_MODE_RESTART) begin
            state_q <= ST_HALT; // [R16]
          end else if (do_rot) begin
            // first to last; a mode 1 appended order is first rebuilt ascending
            if (mode == `PAC_MODE_APPEND)
              order_q <= ({asc[2:0], 12'h000} >> (3 * (5 - asc_len))) | (asc >> 3); // [R15] [R18]
            else
              order_q <= ({pruned[2:0], 12'h000} >> (3 * (5 - pr_len))) | (pruned >> 3); // [R18]
            len_q       <= (mode == `PAC_MODE_APPEND) ? asc_len : pr_len;
            rot_count_q <= rot_count_q + 8'h01;
          end else if (at_rest) begin
            state_q <= ST_STOP;
            if (mode == `PAC_MODE_APPEND) begin
              order_q <= asc; // [R15]
              len_q   <= asc_len;
            end
          end else if (ret_any && mode == `PAC_MODE_APPEND && len_q < 3'd5) begin
            order_q[3*len_q +: 3] <= ret_idx; // [R14]
            len_q <= len_q + 3'd1;
          end else if (|ilk_fall) begin
            order_q <= pruned; // [R11]
            len_q   <= pr_len;
          end
        end
        ST_STOP: begin
          if (do_rot) begin
            order_q     <= ({asc[2:0], 12'h000} >> (3 * (5 - asc_len))) | (asc >> 3); // [R18]
            len_q       <= asc_len;
            rot_count_q <= rot_count_q + 8'h01;
          end else if (len_q == 3'd0 || len_q != asc_len || |ilk_fall || |ilk_rise) begin
            // a scope change alters the motor set, so the idle order is rebuilt too
            order_q <= asc;
            len_q   <= asc_len;
          end
          if (!at_rest)
            state_q <= ST_RUN;
        end
        ST_HALT: begin
          // one cycle with every motor off before the rebuilt start
          order_q <= asc; // [R16]
          len_q   <= asc_len;
          state_q <= at_rest ? ST_STOP : ST_RUN;
        end
        default: state_q <= ST_STOP;
      endcase
    end
  end

  // contactor outputs from the current order
  reg [4:0] line_d;
  reg [4:0] conv_d;
  reg       run_d;
  reg [2:0] mot;
  integer   p;
  always @* begin
    line_d = 5'h00;
    conv_d = 5'h00;
    run_d  = (state_q == ST_RUN) && !stop_evt;
    mot    = 3'd0;
    if (run_d) begin
      for (p = 0; p < 5; p = p + 1) begin
        mot = order_q[3*p +: 3];
        if (p[2:0] < len_q && ilk[mot]) begin // [R11]
          if (scope && p == 0)
            conv_d[mot] = 1'b1; // [R3]
          else if (p[2:0] >= 3'd1 && p[2:0] <= AUX_DEMAND)
            line_d[mot] = 1'b1; // [R2] [R3]
        end
      end
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LINE_CON      <= 5'h00;
      CONV_CON      <= 5'h00;
      DRIVE_RUN     <= 1'b0;
      DISP_VALUE    <= 16'h0000;
      DISP_DECIMALS <= 4'h0;
    end else begin
      LINE_CON      <= line_d & ~conv_d; // [R3]
      CONV_CON      <= conv_d;
      DRIVE_RUN     <= run_d;
      DISP_VALUE    <= disp_w; // [R17]
      DISP_DECIMALS <= ddec_q; // [R17]
    end
  end

  // register port
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q     <= `PAC_CTRL_RST;
      interval_q <= `PAC_INTERVAL_RST;
      maxaux_q   <= `PAC_MAXAUX_RST;
      flimit_q   <= `PAC_FLIMIT_RST;
      imap_q     <= `PAC_IMAP_RST;
      dmin_q     <= 16'h0000;
      dmax_q     <= `PAC_DISP_MAX_RST;
      ddec_q     <= 4'h0;
      RDATA      <= 32'h00000000;
    end else begin
      if (WR) begin
        case (ADDR)
          `PAC_REG_CTRL:     ctrl_q     <= {28'h0000000, WDATA[3:0]};
          `PAC_REG_INTERVAL: interval_q <= WDATA;
          `PAC_REG_MAXAUX:   maxaux_q   <= WDATA[2:0];
          `PAC_REG_FLIMIT:   flimit_q   <= WDATA[15:0];
          `PAC_REG_IMAP:     imap_q     <= WDATA & 32'h00077777;
          `PAC_REG_DISP_MIN: dmin_q     <= WDATA[15:0];
          `PAC_REG_DISP_MAX: dmax_q     <= WDATA[15:0];
          `PAC_REG_DISP_DEC: ddec_q     <= WDATA[3:0];
          default: ;
        endcase
      end
      if (RD) begin
        case (ADDR)
          `PAC_REG_CTRL:     RDATA <= ctrl_q;
          `PAC_REG_INTERVAL: RDATA <= interval_q;
          `PAC_REG_MAXAUX:   RDATA <= {29'h00000000, maxaux_q};
          `PAC_REG_FLIMIT:   RDATA <= {16'h0000, flimit_q};
          `PAC_REG_IMAP:     RDATA <= imap_q;
          `PAC_REG_DISP_MIN: RDATA <= {16'h0000, dmin_q};
          `PAC_REG_DISP_MAX: RDATA <= {16'h0000, dmax_q};
          `PAC_REG_DISP_DEC: RDATA <= {28'h0000000, ddec_q};
          `PAC_REG_STATUS:   RDATA <= {8'h00, rot_count_q, 3'h0, ilk, len_q, pending_q, 1'b0, state_q};
          `PAC_REG_ORDER:    RDATA <= {17'h00000, order_q};
          `PAC_REG_ELAPSED:  RDATA <= elapsed_q;
          `PAC_REG_DISPLAY:  RDATA <= {16'h0000, disp_w};
          default:           RDATA <= 32'h00000000;
        endcase
      end else begin
        RDATA <= 32'h00000000;
      end
    end
  end
endmodule

// ==== pac_map.vh ====
// pump autochange sequencer: register offsets, fields, reset values, timing
// assumes inclusion by bare name from the design files
`ifndef PAC_MAP_VH
`define PAC_MAP_VH
`define PAC_AW                4
`define PAC_REG_CTRL          4'h0
`define PAC_REG_INTERVAL      4'h1
`define PAC_REG_MAXAUX        4'h2
`define PAC_REG_FLIMIT        4'h3
`define PAC_REG_IMAP          4'h4
`define PAC_REG_DISP_MIN      4'h5
`define PAC_REG_DISP_MAX      4'h6
`define PAC_REG_DISP_DEC      4'h7
`define PAC_REG_STATUS        4'h8
`define PAC_REG_ORDER         4'h9
`define PAC_REG_ELAPSED       4'hA
`define PAC_REG_DISPLAY       4'hB
`define PAC_CTRL_EN_BIT       0
`define PAC_CTRL_SCOPE_BIT    1
`define PAC_CTRL_MODE_LO      2
`define PAC_CTRL_MODE_HI      3
`define PAC_CTRL_RST          32'h00000000
`define PAC_INTERVAL_RST      32'h00000000
`define PAC_MAXAUX_RST        3'h4
`define PAC_FLIMIT_RST        16'h0000
`define PAC_IMAP_RST          32'h00003210
`define PAC_DISP_MAX_RST      16'h0064
`define PAC_MODE_NONE         2'h0
`define PAC_MODE_APPEND       2'h1
`define PAC_MODE_RESTART      2'h2
`define PAC_TICK_SECONDS      1
`define PAC_CLK_MHZ           250
`define PAC_TICK_CYCLES       (`PAC_TICK_SECONDS * `PAC_CLK_MHZ * 1000000)
`endif

// ==== pac_tick.v ====
// pac_tick: one-cycle enable pulse every PERIOD clocks
// assumes a single free-running clock
`timescale 1ns/1ps
module pac_tick #(
  parameter [31:0] PERIOD = 32'd250000000
) (
  input  wire CLK,
  input  wire RSTN,
  output reg  tick
);
  reg [31:0] cnt_q;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q <= 32'h00000000;
      tick  <= 1'b0;
    end else if (cnt_q >= PERIOD - 32'd1) begin
      cnt_q <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'd1;
      tick  <= 1'b0;
    end
  end
endmodule

// ==== pac_scale.v ====
// pac_scale: maps a 0..65535 actual value onto min..max-1 of the display span; max itself is never reached
// assumes inputs stable a few cycles; output registered
`timescale 1ns/1ps
module pac_scale (
  input  wire        CLK,
  input  wire        RSTN,
  input  wire [15:0] actual,
  input  wire [15:0] lo,
  input  wire [15:0] hi,
  output reg  [15:0] disp
);
  wire [15:0] span = (hi > lo) ? (hi - lo) : 16'h0000;
  wire [31:0] prod = actual * span;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      disp <= 16'h0000;
    else
      disp <= lo + prod[31:16];
  end
endmodule

// ==== pac_properties.sv ====
// pac_properties: port-level checks of the autochange sequencer
// assumes settings reach the block only through its register port
`timescale 1ns/1ps
`include "pac_map.vh"
module pac_checker (
  input wire               CLK,
  input wire               RSTN,
  input wire [`PAC_AW-1:0] ADDR,
  input wire [31:0]        WDATA,
  input wire               WR,
  input wire               RD,
  input wire [31:0]        RDATA,
  input wire               START_REQ,
  input wire               SLEEP,
  input wire [2:0]         AUX_DEMAND,
  input wire [7:0]         DIG_IN,
  input wire [4:0]         LINE_CON,
  input wire [4:0]         CONV_CON,
  input wire               DRIVE_RUN,
  input wire [3:0]         DISP_DECIMALS
);
  reg  [3:0]  ctrl_q;
  reg  [31:0] imap_q;
  reg  [3:0]  dec_q;
  wire [4:0]  ilk;
  genvar      k;
  // shadow copies, so no check needs to peek inside
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= 4'h0;
      imap_q <= 32'h00003210;
      dec_q  <= 4'h0;
    end else if (WR) begin
      if (ADDR == 4'h0) ctrl_q <= WDATA[3:0];
      if (ADDR == 4'h4) imap_q <= WDATA;
      if (ADDR == 4'h7) dec_q <= WDATA[3:0];
    end
  end
  for (k = 0; k < 5; k = k + 1) begin : g_ilk
    assign ilk[k] = DIG_IN[imap_q[4*k +: 3]];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // four cycles allow for input sampling plus the registered contactors
  sequence ilk_steady;
    (ctrl_q[3:2] != 2'h0 && $stable(ilk) && $stable(ctrl_q))[*4];
  endsequence
  sequence quiet_run;
    (START_REQ && !SLEEP && DRIVE_RUN && ctrl_q[3:2] == 2'h0 && !ctrl_q[0] && $stable(ctrl_q)
     && $stable(AUX_DEMAND))[*6];
  endsequence
  ctrl_readback_a: assert property (RD && ADDR == 4'h0 |=> RDATA == {28'h0, ctrl_q})
    else $error("control register reads back wrong");
  scope_fixed_a: assert property ((!ctrl_q[1])[*3] |-> CONV_CON == 5'h00 && !LINE_CON[4])
    else $error("own motor switched in auxiliary-only scope");
  contactor_excl_a: assert property ((LINE_CON & CONV_CON) == 5'h00 && $onehot0(CONV_CON))
    else $error("motor on line and converter at once");
  interlock_gate_a: assert property (ilk_steady |-> ((LINE_CON | CONV_CON) & ~ilk) == 5'h00)
    else $error("motor commanded without interlock");
  feedback_ignored_a: assert property (quiet_run |-> $stable({LINE_CON, CONV_CON}))
    else $error("contactors moved with feedback ignored");
  stop_idle_a: assert property ((!START_REQ)[*3] |-> !DRIVE_RUN && (LINE_CON | CONV_CON) == 5'h00)
    else $error("motors running while stopped");
  decimals_pass_a: assert property ($stable(dec_q)[*4] |-> DISP_DECIMALS == dec_q)
    else $error("decimals output differs from setting");
  rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside its slot");
endmodule
bind pac_autochange pac_checker i_pac_checker (
  .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .START_REQ(START_REQ), .SLEEP(SLEEP), .AUX_DEMAND(AUX_DEMAND), .DIG_IN(DIG_IN),
  .LINE_CON(LINE_CON), .CONV_CON(CONV_CON), .DRIVE_RUN(DRIVE_RUN), .DISP_DECIMALS(DISP_DECIMALS)
);

// ==== pac_motor_side.sv ====
// pac_motor_side: contactor bank and interlock selector switches
// assumes the bench sets each switch; spare digital inputs pulled low
`timescale 1ns/1ps
module pac_motor_side (
  input  wire [4:0] auto_sw,
  input  wire [4:0] line_con,
  input  wire [4:0] conv_con,
  output wire [7:0] dig_in,
  output wire       clash
);
  // a motor off auto reports its interlock low
  assign dig_in = {3'h0, auto_sw};
  // both contactors closed would short the converter output
  assign clash = |(line_con & conv_con);
endmodule

// ==== pac_tb.sv ====
// testbench: registers, display and interlock handling of the sequencer
// assumes the one-second tick is out of reach, so no timed rotation runs
`timescale 1ns/1ps
module testbench;
  reg         CLK = 1'b0;
  reg         RSTN = 1'b0;
  reg  [3:0]  ADDR = 4'h0;
  reg  [31:0] WDATA = 32'h0;
  reg         WR = 1'b0;
  reg         RD = 1'b0;
  reg         START_REQ = 1'b0;
  reg         SLEEP = 1'b0;
  reg  [2:0]  AUX_DEMAND = 3'h0;
  reg  [15:0] ACTUAL = 16'h0;
  reg  [4:0]  sw = 5'h1F;
  wire [31:0] RDATA;
  wire [7:0]  DIG_IN;
  wire [4:0]  LINE_CON;
  wire [4:0]  CONV_CON;
  wire        DRIVE_RUN;
  wire [15:0] DISP_VALUE;
  wire [3:0]  DISP_DECIMALS;
  wire        clash;
  integer     fails = 0;
  integer     compares = 0;
  integer     i;
  reg         seen;
  reg  [68:0] rows [0:10];
  always #2 CLK = ~CLK;
  pac_autochange i_pac_autochange (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .START_REQ(START_REQ), .SLEEP(SLEEP), .OUT_FREQ(16'h0000),
    .AUX_DEMAND(AUX_DEMAND), .DIG_IN(DIG_IN), .ACTUAL(ACTUAL), .LINE_CON(LINE_CON),
    .CONV_CON(CONV_CON), .DRIVE_RUN(DRIVE_RUN), .DISP_VALUE(DISP_VALUE), .DISP_DECIMALS(DISP_DECIMALS));
  pac_motor_side i_pac_motor_side (.auto_sw(sw), .line_con(LINE_CON), .conv_con(CONV_CON),
    .dig_in(DIG_IN), .clash(clash));
  task close_out;
    begin
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  always @(posedge CLK) if (clash === 1'b1) chk(32'h1, 32'h0);
  task wr(input [3:0] a, input [31:0] d);
    begin
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK);
      WR    <= 1'b0;
      @(posedge CLK);
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK);
      RD   <= 1'b0;
      #1 chk(RDATA, e);
      @(posedge CLK);
    end
  endtask
  // bounded wait for a contactor pattern; a miss ends the run
  task wl(input [4:0] l, input [4:0] c);
    begin
      seen = 1'b0;
      for (i = 0; i < 12 && !seen; i = i + 1) begin
        @(posedge CLK);
        #1 seen = (LINE_CON === l) && (CONV_CON === c);
      end
      chk({22'h0, LINE_CON, CONV_CON}, {22'h0, l, c});
      if (fails != 0) close_out;
      @(posedge CLK);
    end
  endtask
  task dsp(input [15:0] a, input [15:0] e);
    begin
      ACTUAL <= a;
      repeat (4) @(posedge CLK);
      #1 chk({16'h0, DISP_VALUE}, {16'h0, e});
      chk({28'h0, DISP_DECIMALS}, 32'h5);
      @(posedge CLK);
    end
  endtask
  initial begin
    rows[0]  = {1'b0, 4'h0, 32'h0, 32'h0};
    rows[1]  = {1'b0, 4'h2, 32'h0, 32'h4};
    rows[2]  = {1'b0, 4'h4, 32'h0, 32'h3210};
    rows[3]  = {1'b0, 4'h6, 32'h0, 32'h64};
    rows[4]  = {1'b1, 4'h3, 32'hFFFF1234, 32'h1234};
    rows[5]  = {1'b1, 4'h5, 32'hFFFF0010, 32'h10};
    rows[6]  = {1'b1, 4'h6, 32'h110, 32'h110};
    rows[7]  = {1'b1, 4'h7, 32'h5, 32'h5};
    rows[8]  = {1'b1, 4'hC, 32'h12345678, 32'h0};
    rows[9]  = {1'b1, 4'hA, 32'hFFFF, 32'h0};
    rows[10] = {1'b1, 4'h0, 32'h7, 32'h7};
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    for (int r = 0; r < 11; r = r + 1) begin
      if (rows[r][68]) wr(rows[r][67:64], rows[r][63:32]);
      rd(rows[r][67:64], rows[r][31:0]);
    end
    dsp(16'h8000, 16'h0090);
    dsp(16'hFFFF, 16'h010F);
    AUX_DEMAND <= 3'h2;
    START_REQ  <= 1'b1;
    wl(5'h06, 5'h01);
    sw <= 5'h1D;
    wl(5'h0C, 5'h01);
    sw <= 5'h1F;
    repeat (6) begin
      @(posedge CLK);
      #1 chk({26'h0, DRIVE_RUN, LINE_CON}, {26'h0, 1'b1, 5'h0C});
    end
    @(posedge CLK);
    AUX_DEMAND <= 3'h3;
    wl(5'h1C, 5'h01);
    SLEEP <= 1'b1;
    wl(5'h00, 5'h00);
    SLEEP <= 1'b0;
    wl(5'h0E, 5'h01);
    wr(4'h0, 32'h2);
    sw <= 5'h1B;
    repeat (6) @(posedge CLK);
    wl(5'h0E, 5'h01);
    sw <= 5'h1F;
    wr(4'h0, 32'hB);
    sw <= 5'h1B;
    wl(5'h1A, 5'h01);
    sw <= 5'h1F;
    seen = 1'b0;
    repeat (8) begin
      @(posedge CLK);
      #1 if (LINE_CON === 5'h00 && CONV_CON === 5'h00) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h1);
    wl(5'h0E, 5'h01);
    wr(4'h4, 32'h43250);
    wl(5'h1C, 5'h01);
    START_REQ <= 1'b0;
    wl(5'h00, 5'h00);
    wr(4'h4, 32'h3210);
    wr(4'h0, 32'h5);
    START_REQ <= 1'b1;
    wl(5'h0E, 5'h00);
    RSTN <= 1'b0;
    @(posedge CLK);
    #1 chk({21'h0, DRIVE_RUN, LINE_CON, CONV_CON}, 32'h0);
    @(posedge CLK);
    RSTN <= 1'b1;
    rd(4'h0, 32'h0);
    close_out;
  end
endmodule
